// ### shared/cwalu_consts.svh
// What this block does
// - add-one writes operand plus one in place
// - subtract-one writes operand minus one in place
// - root truncated to hundredths, times 100, stored
// - block sum adds counted words or doublewords
// - block xor combines counted words into destination
// - bitwise and of two sources to destination
// - bitwise or of two sources to destination
// - bitwise xor of two sources to destination
// - left string shift, low bit filled from source
// - right string shift, top bit filled from source
// - string shifts write back, carry gets last out
// - digit shift: to bcd, shift, zero fill, back
// - word block moves up, source into first word
// - rotate left in place, carry gets last out
// - rotate right in place, carry gets last out
// - binary source converted to packed bcd destination
`ifndef CWALU_CONSTS_SVH
`define CWALU_CONSTS_SVH

// ----------------------------------------
// register map, byte offsets
// ----------------------------------------
`define CWALU_OFF_CTRL 8'h00
`define CWALU_OFF_STAT 8'h04
`define CWALU_OFF_SRC1 8'h08
`define CWALU_OFF_SRC2 8'h0c
`define CWALU_OFF_DST 8'h10
`define CWALU_OFF_PARAM 8'h14
`define CWALU_MEM_BASE 8'h80
`define CWALU_MEM_WORDS 32
`define CWALU_HSIZE_WORD 3'h2

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CWALU_CTRL_GO 31
`define CWALU_CTRL_DW 8
`define CWALU_PARAM_LEN 8
`define CWALU_RST_BITS 8'h01
`define CWALU_RST_LEN 5'h0f

// ----------------------------------------
// operation codes
// ----------------------------------------
`define CWALU_OP_INC 5'h00
`define CWALU_OP_SUB_ONE 5'h01
`define CWALU_OP_ROOT 5'h02
`define CWALU_OP_SUMA 5'h03
`define CWALU_OP_SUMX 5'h04
`define CWALU_OP_AND 5'h05
`define CWALU_OP_OR 5'h06
`define CWALU_OP_XOR 5'h07
`define CWALU_OP_SHL 5'h08
`define CWALU_OP_SHR 5'h09
`define CWALU_OP_DIGIT_SHL 5'h0a
`define CWALU_OP_WORD_SHIFT 5'h0b
`define CWALU_OP_ROT_LEFT 5'h0c
`define CWALU_OP_ROT_RIGHT 5'h0d
`define CWALU_OP_BIN_BCD 5'h0e

// ----------------------------------------
// square root
// ----------------------------------------
`define CWALU_SQRT_SCALE 48'h0000_0000_2710
`define CWALU_SQRT_ONE 48'h4000_0000_0000

`endif

// ### shared/cwalu_pkg.sv
`default_nettype none
`include "cwalu_consts.svh"
package cwalu_pkg;
  typedef enum logic [4:0] {
    OP_INC = `CWALU_OP_INC, OP_SUB_ONE = `CWALU_OP_SUB_ONE, OP_ROOT = `CWALU_OP_ROOT,
    OP_SUMA = `CWALU_OP_SUMA, OP_SUMX = `CWALU_OP_SUMX, OP_AND = `CWALU_OP_AND,
    OP_OR = `CWALU_OP_OR, OP_XOR = `CWALU_OP_XOR, OP_SHL = `CWALU_OP_SHL,
    OP_SHR = `CWALU_OP_SHR, OP_DIGIT_SHL = `CWALU_OP_DIGIT_SHL,
    OP_WORD_SHIFT = `CWALU_OP_WORD_SHIFT, OP_ROT_LEFT = `CWALU_OP_ROT_LEFT,
    OP_ROT_RIGHT = `CWALU_OP_ROT_RIGHT, OP_BIN_BCD = `CWALU_OP_BIN_BCD
  } cwalu_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_STEP = 4'b0010,
    S_ROOT = 4'b0100,
    S_WB = 4'b1000
  } cwalu_state_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [15:0] data;
  } cwalu_wr_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] off;
  } cwalu_aph_t;
endpackage
`default_nettype wire

// ### src/cwalu_sqrt.sv
`timescale 1ns/100ps
`default_nettype none
`include "cwalu_consts.svh"

module cwalu_sqrt (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request
  input wire logic start,
  input wire logic [47:0] rad,
  // answer
  output logic done,
  output logic [23:0] root
);
  logic [47:0] rem_ff, nxt_rem;
  logic [47:0] res_ff, nxt_res;
  logic [47:0] one_ff, nxt_one;
  logic [47:0] trial;
  logic done_ff, nxt_done;

  // ----------------------------------------
  // bit-serial root, one result bit per clock
  // ----------------------------------------
  always_comb begin
    trial = res_ff + one_ff;
    nxt_rem = rem_ff;
    nxt_res = res_ff;
    nxt_one = one_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_rem = rad;
      nxt_res = 48'h0;
      nxt_one = `CWALU_SQRT_ONE;
    end else if (one_ff != 48'h0) begin
      if (rem_ff >= trial) begin
        nxt_rem = rem_ff - trial;
        nxt_res = (res_ff >> 1) + one_ff;
      end else begin
        nxt_res = res_ff >> 1;
      end
      nxt_one = one_ff >> 2;
      nxt_done = one_ff == 48'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rem_ff <= 48'h0;
      res_ff <= 48'h0;
      one_ff <= 48'h0;
      done_ff <= 1'b0;
    end else begin
      rem_ff <= nxt_rem;
      res_ff <= nxt_res;
      one_ff <= nxt_one;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
  assign root = res_ff[23:0];
endmodule
`default_nettype wire

// ### src/cwalu_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cwalu_consts.svh"

module cwalu_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sequencer side
  input wire logic cond_in,
  output logic carry_flag_relay
);
  import cwalu_pkg::*;

  logic [15:0] mem_ff [`CWALU_MEM_WORDS];
  logic [15:0] nxt_mem [`CWALU_MEM_WORDS];
  logic [1:0] cond_sync_ff;
  cwalu_aph_t aph_ff, nxt_aph;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hready_ff, hresp_ff;
  cwalu_op_t op_ff, nxt_op;
  logic dword_ff, nxt_dword, go_ff, nxt_go;
  logic [4:0] src1_ff, nxt_src1, src2_ff, nxt_src2, dst_ff, nxt_dst;
  logic [7:0] bits_ff, nxt_bits;
  logic [4:0] len_m1_ff, nxt_len_m1;
  cwalu_state_t st_ff, nxt_st;
  logic [31:0] acc_ff, nxt_acc;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [4:0] idx_ff, nxt_idx;
  logic carry_ff, nxt_carry, skip_ff, nxt_skip;
  cwalu_wr_t wr0, wr1;
  logic busy, start, cfg_ok, mem_wr, fill, str_top, rot_msb, wide, sq_start, sq_done;
  logic [15:0] a16, a16n, b16, blk16;
  logic [31:0] a32, opa, opb, blk32, smask, bcd_a, bcd_dig, bcd_res;
  logic [31:0] bcd_hi, bcd_lo;
  logic [4:0] wb_addr;
  logic [23:0] sq_root;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] bin2bcd(input logic [31:0] v);
    logic [31:0] b;
    b = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      for (int d = 0; d < 8; d++) begin
        if (b[d*4 +: 4] > 4'h4)
          b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
      end
      b = {b[30:0], v[i]};
    end
    return b;
  endfunction

  function automatic logic [15:0] bcd2bin(input logic [15:0] b);
    return {12'h0, b[15:12]} * 16'h03e8 + {12'h0, b[11:8]} * 16'h0064
           + {12'h0, b[7:4]} * 16'h000a + {12'h0, b[3:0]};
  endfunction

  // ----------------------------------------
  // condition input, two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      cond_sync_ff <= 2'b00;
    else
      cond_sync_ff <= {cond_sync_ff[0], cond_in};
  end

  // ----------------------------------------
  // ahb-lite slave, zero wait, always okay
  // ----------------------------------------
  assign busy = st_ff != S_IDLE || go_ff;

  always_comb begin
    nxt_aph.valid = hsel && htrans[1] && hready && hsize == `CWALU_HSIZE_WORD
                    && haddr[31:8] == 24'h0;
    nxt_aph.wr = hwrite;
    nxt_aph.off = {haddr[7:2], 2'b00};
    nxt_hrdata = 32'h0;
    if (nxt_aph.valid && !hwrite) begin
      if (haddr[7])
        nxt_hrdata = {16'h0, mem_ff[haddr[6:2]]};
      else
        case (nxt_aph.off)
          `CWALU_OFF_CTRL: nxt_hrdata = {23'h0, dword_ff, 3'h0, op_ff};
          `CWALU_OFF_STAT: nxt_hrdata = {29'h0, skip_ff, carry_ff, busy};
          `CWALU_OFF_SRC1: nxt_hrdata = {27'h0, src1_ff};
          `CWALU_OFF_SRC2: nxt_hrdata = {27'h0, src2_ff};
          `CWALU_OFF_DST: nxt_hrdata = {27'h0, dst_ff};
          `CWALU_OFF_PARAM: nxt_hrdata = {19'h0, len_m1_ff, bits_ff};
          default: nxt_hrdata = 32'h0;
        endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aph_ff <= '0;
      hrdata_ff <= 32'h0;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      aph_ff <= nxt_aph;
      hrdata_ff <= nxt_hrdata;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // operation set-up registers
  // ----------------------------------------
  // set-up is frozen while an operation runs so operands cannot move under it
  assign cfg_ok = aph_ff.valid && aph_ff.wr && !aph_ff.off[7] && !busy;
  assign mem_wr = aph_ff.valid && aph_ff.wr && aph_ff.off[7];

  always_comb begin
    nxt_op = op_ff;
    nxt_dword = dword_ff;
    nxt_go = 1'b0;
    nxt_src1 = src1_ff;
    nxt_src2 = src2_ff;
    nxt_dst = dst_ff;
    nxt_bits = bits_ff;
    nxt_len_m1 = len_m1_ff;
    if (aph_ff.valid && aph_ff.wr && aph_ff.off == `CWALU_OFF_CTRL)
      nxt_go = hwdata[`CWALU_CTRL_GO];
    if (cfg_ok)
      case (aph_ff.off)
        `CWALU_OFF_CTRL: begin
          nxt_op = cwalu_op_t'(hwdata[4:0]);
          nxt_dword = hwdata[`CWALU_CTRL_DW];
        end
        `CWALU_OFF_SRC1: nxt_src1 = hwdata[4:0];
        `CWALU_OFF_SRC2: nxt_src2 = hwdata[4:0];
        `CWALU_OFF_DST: nxt_dst = hwdata[4:0];
        `CWALU_OFF_PARAM: begin
          nxt_bits = hwdata[7:0];
          nxt_len_m1 = hwdata[`CWALU_PARAM_LEN +: 5];
        end
        default: nxt_go = nxt_go;
      endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_ff <= OP_INC;
      dword_ff <= 1'b0;
      go_ff <= 1'b0;
      src1_ff <= 5'h0;
      src2_ff <= 5'h0;
      dst_ff <= 5'h0;
      bits_ff <= `CWALU_RST_BITS;
      len_m1_ff <= `CWALU_RST_LEN;
    end else begin
      op_ff <= nxt_op;
      dword_ff <= nxt_dword;
      go_ff <= nxt_go;
      src1_ff <= nxt_src1;
      src2_ff <= nxt_src2;
      dst_ff <= nxt_dst;
      bits_ff <= nxt_bits;
      len_m1_ff <= nxt_len_m1;
    end
  end

  // ----------------------------------------
  // operand fetch and one-shot results
  // ----------------------------------------
  // upper word sits at the lower index of a doubleword
  assign a16 = mem_ff[src1_ff];
  assign a16n = mem_ff[src1_ff + 5'h01];
  assign b16 = mem_ff[src2_ff];
  assign a32 = {a16, a16n};
  assign opa = dword_ff ? a32 : {16'h0, a16};
  assign opb = dword_ff ? {b16, mem_ff[src2_ff + 5'h01]} : {16'h0, b16};
  assign blk16 = mem_ff[idx_ff];
  assign blk32 = {blk16, mem_ff[idx_ff + 5'h01]};
  assign fill = b16[0];
  assign smask = ~(32'hffff_fffe << len_m1_ff);
  assign str_top = acc_ff[len_m1_ff];
  assign rot_msb = dword_ff ? acc_ff[31] : acc_ff[15];
  assign bcd_a = bin2bcd(opa);
  // out-of-range words give garbage digits; the issuer keeps them in range
  assign bcd_hi = bin2bcd({16'h0, a16});
  assign bcd_lo = bin2bcd({16'h0, a16n});
  assign bcd_dig = {bcd_hi[15:0], bcd_lo[15:0]} << {b16[2:0], 2'b00};
  assign bcd_res = {bcd2bin(bcd_dig[31:16]), bcd2bin(bcd_dig[15:0])};
  assign start = st_ff == S_IDLE && go_ff && cond_sync_ff[1];
  assign wide = (dword_ff && op_ff != OP_SUMX) || op_ff == OP_DIGIT_SHL;
  assign wb_addr = (op_ff == OP_INC || op_ff == OP_SUB_ONE || op_ff == OP_DIGIT_SHL
                    || op_ff == OP_SHL || op_ff == OP_SHR || op_ff == OP_ROT_LEFT
                    || op_ff == OP_ROT_RIGHT)
                   ? src1_ff : dst_ff;

  cwalu_sqrt u_sqrt (
    .clk(clk),
    .rst_b(rst_b),
    .start(sq_start),
    .rad({16'h0, opa} * `CWALU_SQRT_SCALE),
    .done(sq_done),
    .root(sq_root)
  );

  // ----------------------------------------
  // execution sequencer
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_carry = carry_ff;
    nxt_skip = skip_ff;
    sq_start = 1'b0;
    wr0 = '0;
    wr1 = '0;
    if (go_ff && !start)
      nxt_skip = 1'b1;
    case (st_ff)
      S_IDLE: if (start) begin
        nxt_skip = 1'b0;
        nxt_st = S_WB;
        nxt_cnt = bits_ff;
        nxt_acc = opa;
        case (op_ff)
          OP_INC: nxt_acc = opa + 32'h1;
          OP_SUB_ONE: nxt_acc = opa - 32'h1;
          OP_AND: nxt_acc = opa & opb;
          OP_OR: nxt_acc = opa | opb;
          OP_XOR: nxt_acc = opa ^ opb;
          OP_BIN_BCD: nxt_acc = bcd_a;
          OP_DIGIT_SHL: nxt_acc = bcd_res;
          OP_ROOT: begin
            nxt_st = S_ROOT;
            sq_start = 1'b1;
          end
          OP_SUMA, OP_SUMX: begin
            nxt_acc = 32'h0;
            nxt_idx = src1_ff;
            nxt_cnt = b16[7:0];
            nxt_st = S_STEP;
          end
          OP_WORD_SHIFT, OP_SHL, OP_SHR, OP_ROT_LEFT, OP_ROT_RIGHT: begin
            if (op_ff == OP_WORD_SHIFT)
              nxt_cnt = b16[7:0];
            nxt_st = S_STEP;
          end
          default: nxt_st = S_IDLE;
        endcase
      end
      S_STEP: if (cnt_ff == 8'h00) begin
        nxt_st = op_ff == OP_WORD_SHIFT ? S_IDLE : S_WB;
      end else begin
        nxt_cnt = cnt_ff - 8'h01;
        case (op_ff)
          OP_SUMA: begin
            nxt_acc = acc_ff + (dword_ff ? blk32 : {16'h0, blk16});
            nxt_idx = idx_ff + (dword_ff ? 5'h02 : 5'h01);
          end
          OP_SUMX: begin
            nxt_acc = acc_ff ^ {16'h0, blk16};
            nxt_idx = idx_ff + 5'h01;
          end
          OP_WORD_SHIFT: begin
            // top word first, so no word is overwritten before it moves
            wr0.en = 1'b1;
            wr0.addr = dst_ff + cnt_ff[4:0] - 5'h01;
            wr0.data = cnt_ff == 8'h01 ? acc_ff[15:0] : mem_ff[dst_ff + cnt_ff[4:0] - 5'h02];
          end
          OP_SHL: begin
            nxt_carry = str_top;
            nxt_acc = (acc_ff & ~smask) | ({acc_ff[30:0], fill} & smask);
          end
          OP_SHR: begin
            nxt_carry = acc_ff[0];
            nxt_acc = (acc_ff & ~smask) | ((acc_ff & smask) >> 1)
                      | ({31'h0, fill} << len_m1_ff);
          end
          OP_ROT_LEFT: begin
            nxt_carry = rot_msb;
            nxt_acc = dword_ff ? {acc_ff[30:0], acc_ff[31]} : {16'h0, acc_ff[14:0], acc_ff[15]};
          end
          OP_ROT_RIGHT: begin
            nxt_carry = acc_ff[0];
            nxt_acc = dword_ff ? {acc_ff[0], acc_ff[31:1]} : {16'h0, acc_ff[0], acc_ff[15:1]};
          end
          default: nxt_st = S_WB;
        endcase
      end
      S_ROOT: if (sq_done) begin
        nxt_acc = {8'h00, sq_root};
        nxt_st = S_WB;
      end
      S_WB: begin
        wr0.en = 1'b1;
        wr0.addr = wb_addr;
        wr0.data = wide ? acc_ff[31:16] : acc_ff[15:0];
        wr1.en = wide;
        wr1.addr = wb_addr + 5'h01;
        wr1.data = acc_ff[15:0];
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= S_IDLE;
      acc_ff <= 32'h0;
      cnt_ff <= 8'h00;
      idx_ff <= 5'h0;
      carry_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      carry_ff <= nxt_carry;
      skip_ff <= nxt_skip;
    end
  end

  // ----------------------------------------
  // data memory, engine write wins over bus write
  // ----------------------------------------
  for (genvar g = 0; g < `CWALU_MEM_WORDS; g++) begin : g_mem
    always_comb begin
      nxt_mem[g] = mem_ff[g];
      if (mem_wr && aph_ff.off[6:2] == 5'(g))
        nxt_mem[g] = hwdata[15:0];
      if (wr0.en && wr0.addr == 5'(g))
        nxt_mem[g] = wr0.data;
      if (wr1.en && wr1.addr == 5'(g))
        nxt_mem[g] = wr1.data;
    end
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
        mem_ff[g] <= 16'h0;
      else
        mem_ff[g] <= nxt_mem[g];
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign carry_flag_relay = carry_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rot_left2;
    start && op_ff == OP_ROT_LEFT && bits_ff == 8'h02;
  endsequence
  sequence s_rot_run;
    st_ff == S_STEP [*3] ##1 st_ff == S_WB ##1 st_ff == S_IDLE;
  endsequence
  property p_inc; start && op_ff == OP_INC |=> acc_ff == $past(opa) + 32'h1; endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_sub_one; start && op_ff == OP_SUB_ONE |=> acc_ff == $past(opa) - 32'h1; endproperty
  a_sub_one: assert property (p_sub_one) else $error("decrement wrong");
  property p_root; start && op_ff == OP_ROOT |-> ##[2:30] st_ff == S_WB; endproperty
  a_root: assert property (p_root) else $error("root never finished");
  property p_sum;
    st_ff == S_STEP && op_ff == OP_SUMA && !dword_ff && cnt_ff != 8'h00
      |=> acc_ff == $past(acc_ff) + {16'h0, $past(blk16)};
  endproperty
  a_sum: assert property (p_sum) else $error("block add wrong");
  property p_sumx;
    st_ff == S_STEP && op_ff == OP_SUMX && cnt_ff != 8'h00
      |=> acc_ff[15:0] == ($past(acc_ff[15:0]) ^ $past(blk16));
  endproperty
  a_sumx: assert property (p_sumx) else $error("block xor wrong");
  property p_and; start && op_ff == OP_AND |=> acc_ff == ($past(opa) & $past(opb)); endproperty
  a_and: assert property (p_and) else $error("and wrong");
  property p_or; start && op_ff == OP_OR |=> acc_ff == ($past(opa) | $past(opb)); endproperty
  a_or: assert property (p_or) else $error("or wrong");
  property p_xor; start && op_ff == OP_XOR |=> acc_ff == ($past(opa) ^ $past(opb)); endproperty
  a_xor: assert property (p_xor) else $error("xor wrong");
  property p_shl;
    st_ff == S_STEP && op_ff == OP_SHL && cnt_ff != 8'h00
      |=> acc_ff[0] == $past(fill) && carry_ff == $past(str_top);
  endproperty
  a_shl: assert property (p_shl) else $error("left string shift wrong");
  property p_shr;
    st_ff == S_STEP && op_ff == OP_SHR && cnt_ff != 8'h00
      |=> carry_ff == $past(acc_ff[0]) && str_top == $past(fill);
  endproperty
  a_shr: assert property (p_shr) else $error("right string shift wrong");
  property p_digit_shl;
    start && op_ff == OP_DIGIT_SHL && a16 == 16'h04d2 && a16n == 16'h162e && b16[2:0] == 3'h3
      |=> acc_ff == 32'h11d7_1f40;
  endproperty
  a_digit_shl: assert property (p_digit_shl) else $error("digit shift wrong");
  property p_word_shift;
    st_ff == S_STEP && op_ff == OP_WORD_SHIFT && cnt_ff == 8'h01
      |-> wr0.en && wr0.addr == dst_ff && wr0.data == acc_ff[15:0];
  endproperty
  a_word_shift: assert property (p_word_shift) else $error("word shift wrong");
  property p_rot_left; s_rot_left2 |=> s_rot_run; endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate length wrong");
  property p_rot_right;
    st_ff == S_STEP && op_ff == OP_ROT_RIGHT && cnt_ff != 8'h00
      |=> carry_ff == $past(acc_ff[0]) && rot_msb == carry_ff;
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");
  property p_bin_bcd;
    start && op_ff == OP_BIN_BCD && !dword_ff && a16 == 16'h270f |=> acc_ff[15:0] == 16'h9999;
  endproperty
  a_bin_bcd: assert property (p_bin_bcd) else $error("bcd conversion wrong");
  property p_cond; go_ff && !cond_sync_ff[1] |=> st_ff == S_IDLE && skip_ff; endproperty
  a_cond: assert property (p_cond) else $error("ran without condition");
endmodule
`default_nettype wire

// ### sim/cwalu_seq_model.sv
`timescale 1ns/100ps
`default_nettype none

module cwalu_seq_model (
  // clock and bus answer
  input wire logic clk,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // sequencer condition
  output logic cond_in
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cond_in = 1'b0;
  end

  // ----------------------------------------
  // single word transfer, held until hready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    // released data lines must not look like a held value
    hwdata <= ~d;
  endtask

  // condition needs two sync edges, so hold before the next go
  task automatic set_cond(input logic v);
    @(posedge clk);
    cond_in <= v;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### sim/controller_word_alu_ops_tb.sv
`timescale 1ns/100ps
`default_nettype none

module controller_word_alu_ops_tb;
  import cwalu_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, cond_in, carry_flag_relay;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total = 0;
  int total_checks = 0;
  cwalu_op_t ops [3] = '{OP_AND, OP_OR, OP_XOR};
  logic [15:0] lexp [3] = '{16'hf000, 16'hfff3, 16'h0ff3};

  always #50 clk = ~clk;

  cwalu_top cwalu_top_i (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cond_in(cond_in), .carry_flag_relay(carry_flag_relay));

  cwalu_seq_model cwalu_seq_model_i (.clk(clk), .hrdata(hrdata), .hready(hreadyout),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .cond_in(cond_in));

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    cwalu_seq_model_i.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    cwalu_seq_model_i.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic setm(input int i, input logic [15:0] v);
    wr(32'h80 + 32'(4 * i), {16'h0, v});
  endtask

  task automatic chk(input int i, input logic [15:0] e);
    logic [31:0] q;
    rd(32'h80 + 32'(4 * i), q);
    cmp(q, {16'h0, e});
  endtask

  task automatic cy(input logic e);
    cmp({31'h0, carry_flag_relay}, {31'h0, e});
  endtask

  // polling is bounded; a stuck busy stops polling after 100 status reads and the run goes on
  task automatic go(input cwalu_op_t op, input logic dw);
    logic [31:0] q;
    int n;
    wr(32'h0, {1'b1, 22'h0, dw, 3'h0, op});
    repeat (2) @(posedge clk);
    n = 0;
    do begin
      rd(32'h4, q);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog: fires after 20000 cycles; whole run needs well under that
  // ----------------------------------------
  initial begin
    #(20000 * 100);
    err_total++;
    test_done();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    cwalu_seq_model_i.set_cond(1'b1);
    wr(32'h0c, 32'h0000_000a);
    wr(32'h10, 32'h0000_0014);
    // word 10: count 3, fill bit 1, digit count 3
    setm(10, 16'hff03);
    setm(0, 16'hffff);
    go(OP_INC, 1'b0);
    chk(0, 16'h0000);
    setm(0, 16'h0001);
    setm(1, 16'hffff);
    go(OP_INC, 1'b1);
    chk(0, 16'h0002);
    chk(1, 16'h0000);
    go(OP_SUB_ONE, 1'b1);
    chk(0, 16'h0001);
    chk(1, 16'hffff);
    setm(0, 16'hf0f0);
    for (int k = 0; k < 3; k++) begin
      go(ops[k], 1'b0);
      chk(20, lexp[k]);
    end
    setm(0, 16'h0002);
    go(OP_ROOT, 1'b0);
    chk(20, 16'h008d);
    setm(0, 16'h0001);
    setm(1, 16'h0002);
    setm(2, 16'h0007);
    go(OP_SUMA, 1'b0);
    chk(20, 16'h000a);
    go(OP_SUMX, 1'b0);
    chk(20, 16'h0004);
    setm(0, 16'h270f);
    go(OP_BIN_BCD, 1'b0);
    chk(20, 16'h9999);
    setm(0, 16'h04d2);
    setm(1, 16'h162e);
    go(OP_DIGIT_SHL, 1'b0);
    chk(0, 16'h11d7);
    chk(1, 16'h1f40);
    setm(0, 16'h5555);
    for (int k = 0; k < 4; k++) setm(20 + k, 16'h00a1 + 16'(k * 17));
    go(OP_WORD_SHIFT, 1'b0);
    chk(20, 16'h5555);
    chk(21, 16'h00a1);
    chk(22, 16'h00b2);
    chk(23, 16'h00d4);
    wr(32'h14, 32'h0000_0f04);
    setm(0, 16'h8421);
    go(OP_SHL, 1'b0);
    chk(0, 16'h421f);
    cy(1'b0);
    wr(32'h14, 32'h0000_0f03);
    setm(0, 16'h8424);
    go(OP_SHR, 1'b0);
    chk(0, 16'hf084);
    cy(1'b1);
    wr(32'h14, 32'h0000_0001);
    setm(0, 16'h8001);
    go(OP_ROT_LEFT, 1'b0);
    chk(0, 16'h0003);
    cy(1'b1);
    wr(32'h14, 32'h0000_0002);
    go(OP_ROT_LEFT, 1'b0);
    chk(0, 16'h000c);
    cy(1'b0);
    wr(32'h14, 32'h0000_0001);
    setm(0, 16'h8001);
    go(OP_ROT_RIGHT, 1'b0);
    chk(0, 16'hc000);
    cy(1'b1);
    cwalu_seq_model_i.set_cond(1'b0);
    setm(0, 16'h1234);
    go(OP_INC, 1'b0);
    chk(0, 16'h1234);
    rd(32'h4, r);
    cmp({31'h0, r[2]}, 32'h1);
    rd(32'h40, r);
    cmp(r, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
